// file: rtl/dacbe_lane.sv
// Purpose: one channel: offset, dither, segment encoding with element mixing
// Assumes: shared mode bits arrive as plain ports
// Notes: outputs registered
module dacbe_lane
  import dacbe_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic mix_en_in,
  input wire logic dith_en_in,
  input wire logic act_sel_in,
  dacbe_lane_if.lane lane
);
  logic [DACBE_RATE_W-1:0] dith_cnt_reg;
  logic [DACBE_RATE_W-1:0] mix_cnt_reg;
  logic [DACBE_DITH_W-1:0] dith_val_reg;
  logic dith_neg_reg;
  logic [3:0] rot_reg;
  logic signed [DACBE_OFS_W-1:0] ofs_sat;
  logic signed [DACBE_OFS_W-1:0] lim;
  logic signed [DACBE_WIDE_W-1:0] wide;
  logic [DACBE_WIDE_W-1:0] ob;
  logic [DACBE_SAMPLE_W-1:0] code;
  logic [DACBE_MSB_SEGS-1:0] msb_raw;
  logic [DACBE_MID_SEGS-1:0] mid_raw;
  logic signed [DACBE_WIDE_W-1:0] dsum;

  always_comb begin
    lim = dith_en_in ? DACBE_OFS_LIM_DITH : DACBE_OFS_LIM_NODITH;
    ofs_sat = $signed(lane.offset);
    if ($signed(lane.offset) > lim) begin
      ofs_sat = lim;
    end else if ($signed(lane.offset) < -lim) begin
      ofs_sat = -lim;
    end
    // two extra bits so offset plus dither never clip the input range
    dsum = dith_neg_reg ? -$signed({15'h0000, dith_val_reg}) : $signed({15'h0000, dith_val_reg});
    wide = $signed({{2{lane.sample[DACBE_SAMPLE_W-1]}}, lane.sample})
      + $signed({{2{ofs_sat[DACBE_OFS_W-1]}}, ofs_sat})
      + (dith_en_in ? dsum : 18'sh00000);
    // offset binary: -32768 -> all zero, all current to negative leg
    ob = wide + 18'sh08000;
    code = ob[DACBE_WIDE_W-1] ? 16'h0000 : (ob[DACBE_SAMPLE_W] ? 16'hffff : ob[15:0]);
    msb_raw = '0;
    mid_raw = '0;
    for (int i = 0; i < DACBE_MSB_SEGS - 1; i++) begin
      msb_raw[i] = (i < code[15:12]);
      mid_raw[i] = (i < code[11:8]);
    end
  end

  // dither value refresh; rate 0 changes every cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dith_cnt_reg <= '0;
      dith_val_reg <= '0;
      dith_neg_reg <= 1'b0;
    end else if (dith_cnt_reg >= lane.dith_rate) begin
      dith_cnt_reg <= '0;
      dith_val_reg <= lane.rnd[2:0];
      dith_neg_reg <= lane.rnd[3];
    end else begin
      dith_cnt_reg <= dith_cnt_reg + 4'h1;
    end
  end

  // rotation moves only on the encoder tick; reduced activity follows data
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mix_cnt_reg <= '0;
      rot_reg <= '0;
    end else if (lane.enc_tick) begin
      if (mix_cnt_reg >= lane.mix_rate) begin
        mix_cnt_reg <= '0;
        rot_reg <= act_sel_in ? (rot_reg ^ code[11:8]) : lane.rnd[7:4];
      end else begin
        mix_cnt_reg <= mix_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      lane.msb_therm <= '0;
      lane.mid_therm <= '0;
      lane.lsb_bin <= '0;
      lane.dith_sw <= '0;
      lane.sat_flag <= 1'b0;
    end else begin
      lane.msb_therm <= mix_en_in ? ((msb_raw << rot_reg) | (msb_raw >> (5'd16 - {1'b0, rot_reg})))
        : msb_raw;
      lane.mid_therm <= mix_en_in ? ((mid_raw << rot_reg) | (mid_raw >> (5'd16 - {1'b0, rot_reg})))
        : mid_raw;
      lane.lsb_bin <= code[7:0];
      lane.dith_sw <= dith_en_in ? {dith_neg_reg, dith_val_reg} : 4'h0;
      lane.sat_flag <= (ofs_sat != $signed(lane.offset));
    end
  end
endmodule : dacbe_lane

// file: rtl/dacbe_lane_if.sv
// Purpose: carries one channel's settings and codes between top and lane
// Assumes: single clock domain
// Notes: one instance per channel
interface dacbe_lane_if;
  import dacbe_pkg::*;
  logic [DACBE_SAMPLE_W-1:0] sample;
  logic [DACBE_OFS_W-1:0] offset;
  logic [DACBE_RATE_W-1:0] dith_rate;
  logic [DACBE_RATE_W-1:0] mix_rate;
  logic [15:0] rnd;
  logic enc_tick;
  logic [DACBE_MSB_SEGS-1:0] msb_therm;
  logic [DACBE_MID_SEGS-1:0] mid_therm;
  logic [DACBE_LSB_BITS-1:0] lsb_bin;
  logic [DACBE_DITH_W:0] dith_sw;
  logic sat_flag;
  modport top (output sample, offset, dith_rate, mix_rate, rnd, enc_tick,
               input msb_therm, mid_therm, lsb_bin, dith_sw, sat_flag);
  modport lane (input sample, offset, dith_rate, mix_rate, rnd, enc_tick,
                output msb_therm, mid_therm, lsb_bin, dith_sw, sat_flag);
endinterface : dacbe_lane_if

// file: rtl/dacbe_pkg.sv
// Purpose: constants and types for the dual-channel converter digital back-end
// Assumes: 32-bit apb register access, one aligned word per register
// Notes: register offsets are byte addresses
// Contract
// - two channels, 16-bit sample codes each
// - codes map linearly, two's complement to current
// - most negative code steers all current negative
// - thermometer upper and middle, binary low bits
// - mixing randomizes thermometer segment selection
// - rate and activity control mixing shifts
// - activity select 1 reduced, 0 normal
// - dither adds one of eight values, cancelled
// - widened datapath keeps full 16-bit range
// - dither rate sets how often value changes
// - per-channel offset, index 0 a, 1 b
// - dither on: offset saturated to plus/minus 128
// - dither off: offset saturated to plus/minus 3968
// - coarse 0-15, fine 0-63, shared doubling
// - encoder runs at one sixteenth, sysref aligned
// - 64b/66b: K equals 256*E/F
// - dual-edge mode presents two samples per clock; the code presents one per clock, alternating between the pair
package dacbe_pkg;
  localparam int unsigned DACBE_SAMPLE_W = 16;
  localparam int unsigned DACBE_WIDE_W = 18;
  localparam int unsigned DACBE_OFS_W = 16;
  localparam int unsigned DACBE_MSB_BITS = 4;
  localparam int unsigned DACBE_MID_BITS = 4;
  localparam int unsigned DACBE_LSB_BITS = 8;
  localparam int unsigned DACBE_MSB_SEGS = 16;
  localparam int unsigned DACBE_MID_SEGS = 16;
  localparam int unsigned DACBE_DITH_W = 3;
  localparam int unsigned DACBE_RATE_W = 4;
  localparam int unsigned DACBE_DIV = 16;
  localparam int unsigned DACBE_DIV_W = 4;
  localparam logic signed [DACBE_OFS_W-1:0] DACBE_OFS_LIM_DITH = 16'sh0080;
  localparam logic signed [DACBE_OFS_W-1:0] DACBE_OFS_LIM_NODITH = 16'sh0f80;
  localparam logic [DACBE_DIV_W-1:0] DACBE_DIV_LAST = 4'hf;
  localparam logic [15:0] DACBE_LFSR_SEED = 16'hace1;
  localparam logic [15:0] DACBE_LFSR_TAPS = 16'hb400;
  localparam logic [11:0] DACBE_ADDR_CTRL = 12'h000;
  localparam logic [11:0] DACBE_ADDR_OFS_A = 12'h004;
  localparam logic [11:0] DACBE_ADDR_OFS_B = 12'h008;
  localparam logic [11:0] DACBE_ADDR_RATE = 12'h00c;
  localparam logic [11:0] DACBE_ADDR_CUR = 12'h010;
  localparam logic [11:0] DACBE_ADDR_STAT = 12'h014;
  localparam int unsigned DACBE_CTRL_MIX_EN = 0;
  localparam int unsigned DACBE_CTRL_DITH_EN = 1;
  localparam int unsigned DACBE_CTRL_ACT = 2;
  localparam int unsigned DACBE_CTRL_DES = 3;
  localparam int unsigned DACBE_CTRL_SYNTH = 4;
  localparam int unsigned DACBE_CTRL_W = 5;
  localparam logic [DACBE_CTRL_W-1:0] DACBE_CTRL_RST = 5'h00;
  localparam logic [3:0] DACBE_COARSE_RST = 4'hf;
  localparam logic [5:0] DACBE_FINE_RST = 6'h1f;
  typedef enum logic [1:0] {dacbe_idle_t_v, dacbe_wait_t_v, dacbe_run_t_v} dacbe_sync_t;
endpackage : dacbe_pkg

// file: rtl/dacbe_top.sv
// Purpose: dual-channel converter back-end with apb register file
// Assumes: sysref_in synchronous to clk_in; two clks per sample pair in dual-edge
// Notes: segment outputs drive the current-steering array
module dacbe_top
  import dacbe_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic sysref_in,
  input wire logic [DACBE_SAMPLE_W-1:0] sample_a_in,
  input wire logic [DACBE_SAMPLE_W-1:0] sample_b_in,
  input wire logic [DACBE_SAMPLE_W-1:0] sample_a2_in,
  input wire logic [DACBE_SAMPLE_W-1:0] sample_b2_in,
  output logic [DACBE_MSB_SEGS-1:0] msb_a_out,
  output logic [DACBE_MID_SEGS-1:0] mid_a_out,
  output logic [DACBE_LSB_BITS-1:0] lsb_a_out,
  output logic [DACBE_DITH_W:0] dith_a_out,
  output logic [DACBE_MSB_SEGS-1:0] msb_b_out,
  output logic [DACBE_MID_SEGS-1:0] mid_b_out,
  output logic [DACBE_LSB_BITS-1:0] lsb_b_out,
  output logic [DACBE_DITH_W:0] dith_b_out,
  output logic edge_phase_out,
  output logic enc_tick_out,
  output logic [3:0] coarse_current_chan_a_out,
  output logic [3:0] coarse_current_chan_b_out,
  output logic [5:0] fine_current_chan_a_out,
  output logic [5:0] fine_current_chan_b_out,
  output logic current_double_enable_out,
  output logic synth_mode_enable_out
);
  logic [DACBE_CTRL_W-1:0] ctrl_reg;
  logic [DACBE_OFS_W-1:0] channel_offset_value_reg [2];
  logic [4*DACBE_RATE_W-1:0] rate_reg;
  logic [20:0] cur_reg;
  logic [15:0] lfsr_reg;
  logic [DACBE_DIV_W-1:0] div_reg;
  logic sysref_d_reg;
  logic [1:0] sat_sticky_reg;
  logic edge_reg;
  logic wr_en;
  logic rd_hit;
  logic mix_en;
  logic dith_en;
  dacbe_lane_if lane_a ();
  dacbe_lane_if lane_b ();

  assign mix_en = ctrl_reg[DACBE_CTRL_MIX_EN];
  assign dith_en = ctrl_reg[DACBE_CTRL_DITH_EN];
  assign pready_out = 1'b1;
  assign wr_en = psel_in && penable_in && pwrite_in;

  always_comb begin
    rd_hit = 1'b1;
    case (paddr_in)
      DACBE_ADDR_CTRL: prdata_out = {27'h0000000, ctrl_reg};
      DACBE_ADDR_OFS_A: prdata_out = {16'h0000, channel_offset_value_reg[0]};
      DACBE_ADDR_OFS_B: prdata_out = {16'h0000, channel_offset_value_reg[1]};
      DACBE_ADDR_RATE: prdata_out = {16'h0000, rate_reg};
      DACBE_ADDR_CUR: prdata_out = {11'h000, cur_reg};
      DACBE_ADDR_STAT: prdata_out = {26'h0000000, sat_sticky_reg, div_reg};
      default: begin
        prdata_out = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
    pslverr_out = psel_in && penable_in && !rd_hit;
  end

  // apb writes; unmapped address answers pslverr
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctrl_reg <= DACBE_CTRL_RST;
      channel_offset_value_reg[0] <= '0;
      channel_offset_value_reg[1] <= '0;
      rate_reg <= '0;
      cur_reg <= {1'b0, DACBE_FINE_RST, DACBE_FINE_RST, DACBE_COARSE_RST, DACBE_COARSE_RST};
    end else if (wr_en) begin
      case (paddr_in)
        DACBE_ADDR_CTRL: ctrl_reg <= pwdata_in[DACBE_CTRL_W-1:0];
        DACBE_ADDR_OFS_A: channel_offset_value_reg[0] <= pwdata_in[15:0];
        DACBE_ADDR_OFS_B: channel_offset_value_reg[1] <= pwdata_in[15:0];
        DACBE_ADDR_RATE: rate_reg <= pwdata_in[15:0];
        DACBE_ADDR_CUR: cur_reg <= pwdata_in[20:0];
        default: ;
      endcase
    end
  end

  // saturation status; set wins over the write-one clear
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sat_sticky_reg <= '0;
    end else begin
      sat_sticky_reg <= (sat_sticky_reg & ~((wr_en && paddr_in == DACBE_ADDR_STAT) ?
        pwdata_in[5:4] : 2'b00)) | {lane_b.sat_flag, lane_a.sat_flag};
    end
  end

  // divide-by-16 encoder phase, restarted by each sysref rising edge
  // any period the source keeps as a multiple of 16 leaves the phase unmoved
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sysref_d_reg <= 1'b0;
      div_reg <= '0;
    end else begin
      sysref_d_reg <= sysref_in;
      div_reg <= (sysref_in && !sysref_d_reg) ? 4'h1 : div_reg + 4'h1;
    end
  end
  assign enc_tick_out = (div_reg == DACBE_DIV_LAST);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      lfsr_reg <= DACBE_LFSR_SEED;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0], ^(lfsr_reg & DACBE_LFSR_TAPS)};
    end
  end

  // dual-edge: lane alternates between the two interpolated samples
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      edge_reg <= 1'b0;
    end else begin
      edge_reg <= ctrl_reg[DACBE_CTRL_DES] ? !edge_reg : 1'b0;
    end
  end
  assign edge_phase_out = edge_reg;

  assign lane_a.sample = edge_reg ? sample_a2_in : sample_a_in;
  assign lane_b.sample = edge_reg ? sample_b2_in : sample_b_in;
  assign lane_a.offset = channel_offset_value_reg[0];
  assign lane_b.offset = channel_offset_value_reg[1];
  assign lane_a.dith_rate = rate_reg[3:0];
  assign lane_b.dith_rate = rate_reg[7:4];
  assign lane_a.mix_rate = rate_reg[11:8];
  assign lane_b.mix_rate = rate_reg[15:12];
  assign lane_a.rnd = lfsr_reg;
  assign lane_b.rnd = {lfsr_reg[7:0], lfsr_reg[15:8]};
  assign lane_a.enc_tick = enc_tick_out;
  assign lane_b.enc_tick = enc_tick_out;

  dacbe_lane u_lane_a (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .mix_en_in(mix_en),
    .dith_en_in(dith_en),
    .act_sel_in(ctrl_reg[DACBE_CTRL_ACT]),
    .lane(lane_a)
  );
  dacbe_lane u_lane_b (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .mix_en_in(mix_en),
    .dith_en_in(dith_en),
    .act_sel_in(ctrl_reg[DACBE_CTRL_ACT]),
    .lane(lane_b)
  );

  assign msb_a_out = lane_a.msb_therm;
  assign mid_a_out = lane_a.mid_therm;
  assign lsb_a_out = lane_a.lsb_bin;
  assign dith_a_out = lane_a.dith_sw;
  assign msb_b_out = lane_b.msb_therm;
  assign mid_b_out = lane_b.mid_therm;
  assign lsb_b_out = lane_b.lsb_bin;
  assign dith_b_out = lane_b.dith_sw;
  assign coarse_current_chan_a_out = cur_reg[3:0];
  assign coarse_current_chan_b_out = cur_reg[7:4];
  assign fine_current_chan_a_out = cur_reg[13:8];
  assign fine_current_chan_b_out = cur_reg[19:14];
  assign current_double_enable_out = cur_reg[20];
  assign synth_mode_enable_out = ctrl_reg[DACBE_CTRL_SYNTH];
endmodule : dacbe_top

// file: test/dac_core_digital_backend_tb.sv
// Purpose: self-checking bench for the converter back-end
// Assumes: zero-wait register slave, one-cycle sample latency
// Notes: dither is allowed a band of plus or minus seven codes
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t: %h vs %h", $time, a, e); end end
module dac_core_digital_backend_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dacbe_pkg::*;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0;
  logic pwrite_in = 1'b0, sr_en = 1'b0, err, sysref_in;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic [15:0] sample_a_in = 16'h0, sample_b_in = 16'h0, sample_a2_in = 16'h0;
  logic [15:0] sample_b2_in = 16'h0, msb_a_out, mid_a_out, msb_b_out, mid_b_out;
  logic pready_out, pslverr_out, edge_phase_out, enc_tick_out;
  logic current_double_enable_out, synth_mode_enable_out;
  logic [7:0] lsb_a_out, lsb_b_out;
  logic [3:0] dith_a_out, dith_b_out, coarse_current_chan_a_out, coarse_current_chan_b_out;
  logic [5:0] fine_current_chan_a_out, fine_current_chan_b_out;
  int failures = 0, compares = 0;
  dacbe_top dut_u (.*);
  dacbe_sysref_src #(.PERIOD(64)) src_u (.clk_in(clk_in), .en_in(sr_en), .sysref_out(sysref_in));
  initial forever #4 clk_in = ~clk_in;
  function automatic logic [16:0] wgt(input logic b);
    logic [15:0] m;
    logic [15:0] d;
    m = b ? msb_b_out : msb_a_out;
    d = b ? mid_b_out : mid_a_out;
    return 17'($countones(m)) * 17'h1000 + 17'($countones(d)) * 17'h100
           + 17'(b ? lsb_b_out : lsb_a_out);
  endfunction : wgt
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) @(posedge clk_in);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic put(input logic [15:0] a, input logic [15:0] b);
    @(posedge clk_in);
    sample_a_in <= a;
    sample_b_in <= b;
    repeat (2) @(posedge clk_in);
    #1;
  endtask : put
  task automatic t_regs();
    apb(0, DACBE_ADDR_CUR, 0);
    `CHK(rd, 32'h0007dfff)
    apb(1, DACBE_ADDR_CUR, 32'h00103ff0);
    apb(0, 12'h018, 0);
    `CHK({coarse_current_chan_a_out, coarse_current_chan_b_out, fine_current_chan_a_out,
      fine_current_chan_b_out, current_double_enable_out}, 21'h01ff81)
    `CHK({err, rd}, 33'h100000000)
  endtask : t_regs
  task automatic t_code();
    logic [4:0] modes [4] = '{5'h00, 5'h01, 5'h05, 5'h10};
    foreach (modes[i]) begin
      apb(1, DACBE_ADDR_CTRL, 32'(modes[i]));
      put(16'h7fff, 16'h8000);
      `CHK(synth_mode_enable_out, modes[i][4])
      `CHK({wgt(0), wgt(1)}, {17'h0ffff, 17'h00000})
      put(16'hc000, 16'h0000);
      `CHK({wgt(0), wgt(1)}, {17'h04000, 17'h08000})
    end
  endtask : t_code
  task automatic t_ofs();
    logic [16:0] w;
    logic [3:0] d0;
    logic ch = 1'b0;
    apb(1, DACBE_ADDR_CTRL, 0);
    apb(1, DACBE_ADDR_OFS_A, 32'd5000);
    apb(1, DACBE_ADDR_OFS_B, 32'h0000ec78);
    put(16'h0, 16'h0);
    `CHK({wgt(0), wgt(1)}, {17'h08f80, 17'h07080})
    apb(1, DACBE_ADDR_OFS_A, 32'd100);
    put(16'h0, 16'h8000);
    `CHK({wgt(0), wgt(1)}, {17'h08064, 17'h00000})
    apb(1, DACBE_ADDR_OFS_A, 32'd5000);
    apb(1, DACBE_ADDR_RATE, 0);
    apb(1, DACBE_ADDR_CTRL, 32'h2);
    put(16'h0, 16'h0);
    w = wgt(0) - 17'h08080;
    `CHK(w + 17'd7 <= 17'd14, 1'b1)
    d0 = dith_a_out;
    repeat (8) begin
      @(posedge clk_in);
      #1;
      ch |= dith_a_out !== d0;
    end
    `CHK(ch, 1'b1)
    apb(0, DACBE_ADDR_STAT, 0);
    `CHK(rd[5:4], 2'b11)
    // both offsets still saturate, so the set must beat the clear
    apb(1, DACBE_ADDR_STAT, 32'h00000030);
    apb(0, DACBE_ADDR_STAT, 0);
    `CHK(rd[5:4], 2'b11)
  endtask : t_ofs
  task automatic t_des();
    logic [16:0] w0;
    logic e0;
    apb(1, DACBE_ADDR_CTRL, 32'h8);
    sample_a2_in <= 16'h2000;
    put(16'h1000, 16'h0);
    w0 = wgt(0);
    e0 = edge_phase_out;
    @(posedge clk_in);
    #1;
    `CHK({edge_phase_out, 18'(w0) + 18'(wgt(0))}, {~e0, 18'h14f00})
  endtask : t_des
  task automatic t_sync();
    int n = 0;
    sr_en <= 1'b1;
    @(posedge sysref_in);
    repeat (64) begin
      @(posedge clk_in);
      #1;
      n += enc_tick_out;
    end
    `CHK(n, 4)
  endtask : t_sync
  task automatic stop_test();
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  initial begin
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_regs();
    t_code();
    t_ofs();
    t_des();
    t_sync();
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    failures++;
    stop_test();
  end
endmodule : dac_core_digital_backend_tb
bind dacbe_top dacbe_top_assertions chk_u (.*);

// file: test/dacbe_sysref_src.sv
// Purpose: sync pulse source standing in for the far-side generator
// Assumes: pulse period fits every internal clock
// Notes: stays low while disabled, so the divider free-runs
module dacbe_sysref_src #(
  parameter int PERIOD = 64
) (
  input wire logic clk_in,
  input wire logic en_in,
  output logic sysref_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial sysref_out = 1'b0;
  // period 64: multiple of 16 and of each link period
  always @(posedge clk_in) begin
    cnt <= (!en_in || cnt == PERIOD - 1) ? 0 : cnt + 1;
    sysref_out <= en_in && cnt < 4;
  end
endmodule : dacbe_sysref_src

// file: test/dacbe_top_assertions.sv
// Purpose: port-level checks of the converter back-end
// Assumes: single clock, synchronous active-high reset
// Notes: code weight counts segments, so mixing cannot move it
module dacbe_top_assertions
  import dacbe_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic sysref_in,
  input wire logic [15:0] sample_a_in,
  input wire logic [15:0] sample_b_in,
  input wire logic [15:0] msb_a_out,
  input wire logic [15:0] mid_a_out,
  input wire logic [7:0] lsb_a_out,
  input wire logic [15:0] msb_b_out,
  input wire logic [15:0] mid_b_out,
  input wire logic [7:0] lsb_b_out,
  input wire logic edge_phase_out,
  input wire logic enc_tick_out,
  input wire logic [3:0] coarse_current_chan_a_out,
  input wire logic [3:0] coarse_current_chan_b_out,
  input wire logic [5:0] fine_current_chan_a_out,
  input wire logic [5:0] fine_current_chan_b_out,
  input wire logic current_double_enable_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sa_reg;
  logic [15:0] sb_reg;
  logic [4:0] gap_reg;
  logic seen_reg;
  logic wr_cur;
  logic wr_ctl;
  int da;
  int db;
  default clocking dc @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  assign wr_cur = psel_in && penable_in && pwrite_in && paddr_in == DACBE_ADDR_CUR;
  assign wr_ctl = psel_in && penable_in && pwrite_in && paddr_in == DACBE_ADDR_CTRL;
  assign da = $countones(msb_a_out) * 4096 + $countones(mid_a_out) * 256 + int'(lsb_a_out)
              - int'(sa_reg ^ 16'h8000);
  assign db = $countones(msb_b_out) * 4096 + $countones(mid_b_out) * 256 + int'(lsb_b_out)
              - int'(sb_reg ^ 16'h8000);
  always_ff @(posedge clk_in) begin
    sa_reg <= sample_a_in;
    sb_reg <= sample_b_in;
  end
  // a sync pulse may restart the divider, so that gap is not judged
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      gap_reg <= 5'h00;
      seen_reg <= 1'b1;
    end else if (enc_tick_out) begin
      gap_reg <= 5'h00;
      seen_reg <= 1'b0;
    end else begin
      gap_reg <= gap_reg + 5'h01;
      seen_reg <= seen_reg | sysref_in;
    end
  end
  chk_tick_period:
    assert property (enc_tick_out && !seen_reg && !sysref_in |-> gap_reg == 5'h0f)
    else $error("encoder tick spacing is not sixteen cycles");
  chk_tick_single:
    assert property (enc_tick_out |=> !enc_tick_out)
    else $error("encoder tick longer than one cycle");
  chk_tick_after_sync:
    assert property ($rose(sysref_in) |-> ##15 enc_tick_out)
    else $error("no encoder tick after sync pulse");
  chk_cur_hold:
    assert property (!$stable({coarse_current_chan_a_out, fine_current_chan_a_out,
      current_double_enable_out}) |-> $past(wr_cur))
    else $error("current setting moved without a write");
  chk_cur_read:
    assert property (psel_in && penable_in && !pwrite_in && paddr_in == DACBE_ADDR_CUR |->
      prdata_out == {11'h000, current_double_enable_out, fine_current_chan_b_out,
      fine_current_chan_a_out, coarse_current_chan_b_out, coarse_current_chan_a_out})
    else $error("current readback differs from outputs");
  chk_edge_toggle:
    assert property ($changed(edge_phase_out) && !wr_ctl && !$past(wr_ctl) && !$past(wr_ctl, 2)
      |=> $changed(edge_phase_out))
    else $error("edge phase stopped toggling");
  chk_code_bound_a:
    assert property (!$past(sys_rst_in) && !edge_phase_out && !$past(edge_phase_out) |->
      da <= 3975 && da >= -3975)
    else $error("channel a code strays beyond offset limit");
  chk_code_bound_b:
    assert property (!$past(sys_rst_in) && !edge_phase_out && !$past(edge_phase_out) |->
      db <= 3975 && db >= -3975)
    else $error("channel b code strays beyond offset limit");
  cov_sync: cover property ($rose(sysref_in));
  cov_dual: cover property ($changed(edge_phase_out));
  cov_cur_write: cover property (wr_cur);
endmodule : dacbe_top_assertions
